// ==== verilog/tshd_pkg.sv ====
// Package of constants shared by the speed limit and hybrid deviation logic.
package tshd_pkg;
  // ----------------------------------------------------------------------
  // Setting ranges
  // ----------------------------------------------------------------------
  localparam logic [14:0] SPEED_LIMIT_MAX   = 15'h4E20;
  localparam logic [10:0] GAIN_MIN          = 11'h000A;
  localparam logic [10:0] GAIN_MAX          = 11'h07D0;
  localparam logic [12:0] OFFSET_MAX        = 13'h15CA;
  localparam logic [12:0] FILTER_MAX        = 13'h1900;
  localparam logic [1:0]  SCALE_TYPE_MAX    = 2'h2;
  localparam logic [20:0] RATIO_DEN_MIN     = 21'h00_0001;
  localparam logic [20:0] RATIO_DEN_MAX     = 21'h10_0000;
  localparam logic [7:0]  RATIO_NUM_MAX     = 8'hDC;
  localparam logic [27:0] GAP_THRESH_MIN    = 28'h000_0001;
  localparam logic [27:0] GAP_THRESH_MAX    = 28'h800_0000;
  localparam logic [6:0]  CLEAR_REVS_MAX    = 7'h64;
  // ----------------------------------------------------------------------
  // Torque source encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0]  SRC_LIMIT_ONE     = 2'h0;
  localparam logic [1:0]  SRC_ANALOG        = 2'h1;
  localparam logic [1:0]  SRC_LIMIT_PAIR    = 2'h2;
  // ----------------------------------------------------------------------
  // Analog scaling: input counts are 0.359 mV, 16-bit signed, 10 V full scale.
  // ----------------------------------------------------------------------
  localparam int          MV_PER_LSB_E3     = 359;
  localparam logic [19:0] UV_PER_VOLT       = 20'hF_4240;
  localparam int          CLK_HZ            = 25000000;
  localparam int          FILTER_UNIT_NS    = 10000;
  localparam int          FILTER_TICK_CYC   = FILTER_UNIT_NS / (1000000000 / CLK_HZ);
  localparam logic [7:0]  FILTER_TICK_LAST  = 8'(FILTER_TICK_CYC - 1);
  localparam logic [12:0] FILTER_TC_MIN     = 13'h0001;
endpackage

// ==== verilog/tshd_ratio.sv ====
// Encoder to scale count ratio accumulator.
`timescale 1ns/10ps
module tshd_ratio (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Ratio setting
  input  wire logic [7:0]         num,
  input  wire logic [20:0]        den,
  // Scale step in, scaled encoder-unit position out
  input  wire logic               step,
  input  wire logic               dir_neg,
  output logic signed [31:0]      pos
);
  logic [20:0]        rem_r;
  logic [21:0]        rem_sum;
  logic [20:0]        den_safe;
  logic [8:0]         whole;
  logic [20:0]        rem_nxt;
  logic signed [31:0] pos_r;

  // A zero denominator is forced to one so the division never faults.
  assign den_safe = (den < tshd_pkg::RATIO_DEN_MIN) ? tshd_pkg::RATIO_DEN_MIN : den;
  // Each scale step adds num/den encoder counts, or subtracts them when dir_neg; the remainder is carried.
  assign rem_sum  = {1'b0, rem_r} + {14'h0000, num};
  assign whole    = 9'(rem_sum / {1'b0, den_safe});
  assign rem_nxt  = 21'(rem_sum % {1'b0, den_safe});
  assign pos      = pos_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rem_r <= 21'h00_0000;
      pos_r <= 32'sh0000_0000;
    end else if (step) begin
      rem_r <= rem_nxt;
      pos_r <= dir_neg ? pos_r - $signed({23'h00_0000, whole})
                       : pos_r + $signed({23'h00_0000, whole});
    end
  end
endmodule

// ==== verilog/tshd_top.sv ====
// Torque-mode speed limit and full-closed hybrid deviation monitor.
`timescale 1ns/10ps
module tshd_top (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Speed limit settings
  input  wire logic [1:0]         torque_source_select,
  input  wire logic [14:0]        speed_limit_first,
  input  wire logic [14:0]        speed_limit_second,
  input  wire logic [1:0]         zero_clamp_select,
  input  wire logic [10:0]        speed_input_gain,
  input  wire logic signed [13:0] analog_one_offset,
  input  wire logic [12:0]        analog_one_filter,
  // Analog sample and speed loop inputs
  input  wire logic signed [15:0] first_analog_input,
  input  wire logic               zero_clamp_in,
  input  wire logic signed [15:0] speed_request,
  input  wire logic signed [15:0] speed_actual,
  // Full-closed settings
  input  wire logic [1:0]         scale_type_select,
  input  wire logic               scale_direction_invert,
  input  wire logic [7:0]         scale_ratio_numerator,
  input  wire logic [20:0]        scale_ratio_denominator,
  input  wire logic [27:0]        hybrid_gap_threshold,
  input  wire logic [6:0]         hybrid_gap_clear_revs,
  // Position feedback and error clear
  input  wire logic               enc_step,
  input  wire logic               enc_dir_neg,
  input  wire logic               enc_rev_tick,
  input  wire logic               scale_a,
  input  wire logic               scale_b,
  input  wire logic               serial_step,
  input  wire logic               serial_dir_neg,
  input  wire logic               error_clear,
  // Results
  output logic signed [15:0]      speed_command,
  output logic                    speed_limited,
  output logic signed [15:0]      analog_speed_reference,
  output logic signed [31:0]      hybrid_gap,
  output logic                    hybrid_gap_error,
  output logic                    motion_stop
);
  // ----------------------------------------------------------------------
  // Analog path: offset, lag filter, gain
  // ----------------------------------------------------------------------
  logic signed [17:0] ana_corr;
  logic signed [17:0] filt_r;
  logic signed [17:0] filt_nxt;
  logic signed [31:0] filt_diff;
  logic [7:0]         tick_cnt_r;
  logic               tick;
  logic [12:0]        tc_safe;
  logic signed [31:0] spd_from_ana;
  logic signed [47:0] spd_prod;
  logic signed [15:0] ana_ref_r;

  assign ana_corr  = 18'(first_analog_input) + 18'(analog_one_offset);
  assign tick      = (tick_cnt_r == tshd_pkg::FILTER_TICK_LAST);
  assign tc_safe   = (analog_one_filter < tshd_pkg::FILTER_TC_MIN) ?
                     tshd_pkg::FILTER_TC_MIN : analog_one_filter;
  // Lag step per 10 us tick: y += (x - y) / tc, tc zero means no filtering.
  assign filt_diff = 32'(ana_corr) - 32'(filt_r);
  assign filt_nxt  = (analog_one_filter == 13'h0000) ? ana_corr :
                     18'(32'(filt_r) + filt_diff / $signed({19'h0_0000, tc_safe}));
  // Counts times 359 uV give microvolts; times gain over one million gives r/min.
  // The product is kept 48 bits wide because full-scale input at top gain overflows 32.
  assign spd_prod     = 48'(filt_r) * $signed({37'h0_0000_0000, speed_input_gain}) *
                        48'(tshd_pkg::MV_PER_LSB_E3);
  assign spd_from_ana = 32'(spd_prod / $signed({28'h000_0000, tshd_pkg::UV_PER_VOLT}));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_r <= 8'h00;
      filt_r     <= 18'sh0_0000;
      ana_ref_r  <= 16'sh0000;
    end else begin
      tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
      if (tick || (analog_one_filter == 13'h0000))
        filt_r <= filt_nxt;
      ana_ref_r <= 16'(spd_from_ana);
    end
  end
  assign analog_speed_reference = ana_ref_r;

  // ----------------------------------------------------------------------
  // Speed limit selection and clamp
  // ----------------------------------------------------------------------
  logic [14:0]        lim_one_c;
  logic [14:0]        lim_two_c;
  logic signed [16:0] lim_pos;
  logic signed [16:0] lim_neg;
  logic signed [16:0] ana_abs;
  logic               clamp_act;
  logic signed [16:0] req_x;
  logic signed [16:0] cmd_x;
  logic signed [15:0] cmd_r;
  logic               lim_r;

  assign lim_one_c = (speed_limit_first  > tshd_pkg::SPEED_LIMIT_MAX) ?
                     tshd_pkg::SPEED_LIMIT_MAX : speed_limit_first;
  assign lim_two_c = (speed_limit_second > tshd_pkg::SPEED_LIMIT_MAX) ?
                     tshd_pkg::SPEED_LIMIT_MAX : speed_limit_second;
  assign ana_abs   = (ana_ref_r < 0) ? -17'(ana_ref_r) : 17'(ana_ref_r);
  assign lim_pos   = (torque_source_select == tshd_pkg::SRC_ANALOG) ? ana_abs :
                     $signed({2'b00, lim_one_c});
  assign lim_neg   = (torque_source_select == tshd_pkg::SRC_ANALOG) ? ana_abs :
                     (torque_source_select == tshd_pkg::SRC_LIMIT_PAIR) ?
                     $signed({2'b00, lim_two_c}) : $signed({2'b00, lim_one_c});
  // Selection 0 ignores the clamp input; any other value honours it.
  assign clamp_act = (zero_clamp_select != 2'h0) && zero_clamp_in;
  assign req_x     = 17'(speed_request);
  assign cmd_x     = (clamp_act || motion_stop) ? 17'sh0_0000 :
                     (req_x > lim_pos) ? lim_pos :
                     (req_x < -lim_neg) ? -lim_neg : req_x;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_r <= 16'sh0000;
      lim_r <= 1'b0;
    end else begin
      cmd_r <= 16'(cmd_x);
      lim_r <= (17'(speed_actual) >= lim_pos) || (17'(speed_actual) <= -lim_neg);
    end
  end
  assign speed_command = cmd_r;
  assign speed_limited = lim_r;

  // ----------------------------------------------------------------------
  // Scale input synchronisers and decode
  // ----------------------------------------------------------------------
  logic [1:0] a_sync_r;
  logic [1:0] b_sync_r;
  logic       a_d_r;
  logic       b_d_r;
  logic       quad_step;
  logic       quad_neg;
  logic       sc_step;
  logic       sc_neg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      a_sync_r <= 2'b00;
      b_sync_r <= 2'b00;
      a_d_r    <= 1'b0;
      b_d_r    <= 1'b0;
    end else begin
      a_sync_r <= {a_sync_r[0], scale_a};
      b_sync_r <= {b_sync_r[0], scale_b};
      a_d_r    <= a_sync_r[1];
      b_d_r    <= b_sync_r[1];
    end
  end
  assign quad_step = (a_sync_r[1] ^ a_d_r) ^ (b_sync_r[1] ^ b_d_r);
  assign quad_neg  = a_sync_r[1] ^ b_d_r;
  // Type 0 is quadrature, types 1 and 2 are serial scales.
  assign sc_step   = (scale_type_select == 2'h0) ? quad_step : serial_step;
  assign sc_neg    = ((scale_type_select == 2'h0) ? quad_neg : serial_dir_neg) ^
                     scale_direction_invert;

  // ----------------------------------------------------------------------
  // Hybrid deviation
  // ----------------------------------------------------------------------
  logic signed [31:0] scale_pos;
  logic signed [31:0] enc_pos_r;
  logic signed [31:0] gap;
  logic [31:0]        gap_abs;
  logic [6:0]         rev_cnt_r;
  logic               rev_clear;
  logic               err_r;
  logic signed [31:0] gap_r;

  tshd_ratio u_ratio (
    .clock   (clock),
    .rst_n   (rst_n),
    .num     (scale_ratio_numerator),
    .den     (scale_ratio_denominator),
    .step    (sc_step),
    .dir_neg (sc_neg),
    .pos     (scale_pos)
  );

  assign gap       = enc_pos_r - scale_pos;
  assign gap_abs   = (gap < 0) ? 32'(-gap) : 32'(gap);
  assign rev_clear = enc_rev_tick && (hybrid_gap_clear_revs != 7'h00) &&
                     (rev_cnt_r + 7'h01 >= hybrid_gap_clear_revs);

  // The encoder count is rebased to the scale count on clear, so the gap is zero unless a scale step lands in that cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enc_pos_r <= 32'sh0000_0000;
      rev_cnt_r <= 7'h00;
      gap_r     <= 32'sh0000_0000;
    end else begin
      if (rev_clear)
        enc_pos_r <= scale_pos;
      else if (enc_step)
        enc_pos_r <= enc_dir_neg ? enc_pos_r - 32'sh0000_0001 : enc_pos_r + 32'sh0000_0001;
      if (enc_rev_tick)
        rev_cnt_r <= rev_clear ? 7'h00 : rev_cnt_r + 7'h01;
      // The deviation output is registered, so it trails the positions by one cycle.
      gap_r <= gap;
    end
  end

  // Set wins over clear so a fresh excess is never lost.
  always_ff @(posedge clock) begin
    if (!rst_n)
      err_r <= 1'b0;
    else if (gap_abs > {4'h0, hybrid_gap_threshold})
      err_r <= 1'b1;
    else if (error_clear)
      err_r <= 1'b0;
  end

  assign hybrid_gap       = gap_r;
  assign hybrid_gap_error = err_r;
  assign motion_stop      = err_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_excess;
    gap_abs > {4'h0, hybrid_gap_threshold};
  endsequence
  AST_ERR_SET: assert property (@(posedge clock) disable iff (!rst_n)
    s_excess |=> hybrid_gap_error) else $error("gap excess did not raise error");
  AST_ERR_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    hybrid_gap_error && !error_clear |=> hybrid_gap_error) else $error("error dropped");
  AST_STOP: assert property (@(posedge clock) disable iff (!rst_n)
    hybrid_gap_error |=> speed_command == 16'sh0000) else $error("motion not stopped");
  AST_LIM_POS: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> 17'(speed_command) <= $past(lim_pos)) else $error("positive limit exceeded");
  AST_LIM_NEG: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> 17'(speed_command) >= -$past(lim_neg)) else $error("negative limit exceeded");
  AST_CLAMP: assert property (@(posedge clock) disable iff (!rst_n)
    zero_clamp_in && zero_clamp_select != 2'h0 |=> speed_command == 16'sh0000)
    else $error("zero clamp ignored");
  AST_SRC0: assert property (@(posedge clock) disable iff (!rst_n)
    torque_source_select == tshd_pkg::SRC_LIMIT_ONE |-> lim_neg == lim_pos)
    else $error("source zero not symmetric");
  AST_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    rev_clear && !sc_step |=> gap == 32'sh0000_0000) else $error("gap not cleared");
  AST_FILT0: assert property (@(posedge clock) disable iff (!rst_n)
    tick && analog_one_filter == 13'h0000 |=> filt_r == $past(ana_corr))
    else $error("unfiltered path wrong");
endmodule

// ==== verification/tshd_scale_model.sv ====
// External scale model that drives the scale pins of the block.
`timescale 1ns/10ps
module tshd_scale_model (
  // Clock
  input  wire logic clock,
  // Scale pins
  output logic      scale_a,
  output logic      scale_b,
  output logic      serial_step,
  output logic      serial_dir_neg
);
  logic idle_r = 1'b1;
  initial begin
    scale_a = 1'b0;
    scale_b = 1'b0;
    serial_step = 1'b0;
    serial_dir_neg = 1'b0;
  end
  // The direction line means nothing between steps, so it keeps toggling whenever no ser_steps burst runs.
  always @(negedge clock) begin
    if (idle_r) begin
      serial_dir_neg <= ~serial_dir_neg;
    end
  end
  // Steps are issued in scale units; the bench scales its motor steps to match.
  task automatic ser_steps(input int n, input logic neg);
    idle_r = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      serial_dir_neg = neg;
      serial_step = 1'b1;
      @(negedge clock);
      serial_step = 1'b0;
    end
    idle_r = 1'b1;
  endtask
  // Phase A leads B; edges are four cycles apart to clear the input synchronizer.
  task automatic quad_steps(input int n);
    logic [1:0] seq [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      {scale_a, scale_b} = seq[i % 4];
      repeat (3) @(negedge clock);
    end
  endtask
endmodule

// ==== verification/tshd_top_test.sv ====
// Self-checking bench for the speed limit and hybrid deviation block.
`timescale 1ns/10ps
module tshd_top_test;
  typedef struct {int sel; logic signed [31:0] exp;} tshd_note_s;
  tshd_note_s         notes [$];
  tshd_note_s         cur;
  logic signed [31:0] got;
  string              nm [7] = '{"cmd", "limited", "aref", "gap", "err", "stop", "quad"};
  int                 n_mismatch = 0;
  int                 check_count = 0;
  int                 r;
  event               go;
  logic               clock = 1'b0;
  logic               rst_n = 1'b0;
  logic [1:0]         torque_source_select = '0, zero_clamp_select = '0;
  logic [1:0]         scale_type_select = 2'h1;
  logic [14:0]        speed_limit_first = 15'h03E8, speed_limit_second = 15'h01F4;
  logic [10:0]        speed_input_gain = 11'h07D0;
  logic signed [13:0] analog_one_offset = '0;
  logic [12:0]        analog_one_filter = '0;
  logic signed [15:0] first_analog_input = '0, speed_request = '0, speed_actual = '0;
  logic               zero_clamp_in = 1'b0, scale_direction_invert = 1'b0, error_clear = 1'b0;
  logic               enc_step = 1'b0, enc_dir_neg = 1'b0, enc_rev_tick = 1'b0;
  logic [7:0]         scale_ratio_numerator = 8'h01;
  logic [20:0]        scale_ratio_denominator = 21'h00_0001;
  logic [27:0]        hybrid_gap_threshold = 28'h000_0003;
  logic [6:0]         hybrid_gap_clear_revs = '0;
  wire logic          scale_a, scale_b, serial_step, serial_dir_neg;
  logic signed [15:0] speed_command, analog_speed_reference;
  logic signed [31:0] hybrid_gap;
  logic               speed_limited, hybrid_gap_error, motion_stop;
  always #20 clock = ~clock;
  tshd_top dut_u (.clock, .rst_n, .torque_source_select, .speed_limit_first,
    .speed_limit_second, .zero_clamp_select, .speed_input_gain, .analog_one_offset,
    .analog_one_filter, .first_analog_input, .zero_clamp_in, .speed_request, .speed_actual,
    .scale_type_select, .scale_direction_invert, .scale_ratio_numerator,
    .scale_ratio_denominator, .hybrid_gap_threshold, .hybrid_gap_clear_revs, .enc_step,
    .enc_dir_neg, .enc_rev_tick, .scale_a, .scale_b, .serial_step, .serial_dir_neg,
    .error_clear, .speed_command, .speed_limited, .analog_speed_reference, .hybrid_gap,
    .hybrid_gap_error, .motion_stop);
  tshd_scale_model partner_u (.clock, .scale_a, .scale_b, .serial_step, .serial_dir_neg);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic int ana(input longint x, input longint g);
    return int'((x * g * tshd_pkg::MV_PER_LSB_E3) / 1000000);
  endfunction
  task automatic chk(input int sel, input int e);
    notes.push_back('{sel, 32'(e)});
    ->go;
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
  endtask
  task automatic pulse(ref logic s, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      s = 1'b1;
      @(negedge clock);
      s = 1'b0;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // The watcher takes each note in order and compares it with the output its selector names; selector 6 reads the gap.
  always begin
    @(go);
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      case (cur.sel)
        0: got = speed_command;
        1: got = 32'(speed_limited);
        2: got = analog_speed_reference;
        3: got = hybrid_gap;
        4: got = 32'(hybrid_gap_error);
        5: got = 32'(motion_stop);
        default: got = hybrid_gap;
      endcase
      check_count++;
      if (got !== cur.exp) begin
        n_mismatch++;
        $display("BAD %s expected %0d seen %0d", nm[cur.sel], cur.exp, got);
      end
    end
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(77351));
    do_reset();
    speed_request = 16'sh7530;
    speed_actual = 16'sh03E8;
    cyc(3);
    chk(0, 1000);
    chk(1, 1);
    r = $urandom_range(999, 0);
    speed_request = 16'(r);
    speed_actual = '0;
    cyc(3);
    chk(0, r);
    chk(1, 0);
    speed_limit_first = 15'h7FFF;
    speed_request = 16'sh61A8;
    cyc(3);
    chk(0, 20000);
    torque_source_select = 2'h2;
    speed_request = -16'sh7530;
    cyc(3);
    chk(0, -500);
    zero_clamp_in = 1'b1;
    speed_request = 16'sh0064;
    for (int i = 0; i < 4; i++) begin
      zero_clamp_select = 2'(i);
      cyc(3);
      chk(0, i == 0 ? 100 : 0);
    end
    zero_clamp_in = 1'b0;
    torque_source_select = 2'h1;
    first_analog_input = 16'sh2710;
    analog_one_offset = -14'sh03E8;
    speed_request = 16'sh7530;
    cyc(4);
    chk(2, ana(9000, 2000));
    chk(0, ana(9000, 2000));
    first_analog_input = 16'sh1388;
    analog_one_offset = -14'sh1388;
    cyc(4);
    chk(2, 0);
    analog_one_offset = '0;
    first_analog_input = 16'sh2710;
    analog_one_filter = 13'h1900;
    cyc(240);
    chk(2, 0);
    analog_one_filter = 13'h0001;
    cyc(270);
    chk(2, ana(10000, 2000));
    torque_source_select = 2'h0;
    speed_limit_first = 15'h03E8;
    speed_request = 16'sh0064;
    do_reset();
    pulse(enc_step, 3);
    cyc(1);
    chk(3, 3);
    cyc(1);
    chk(4, 0);
    pulse(enc_step, 1);
    cyc(1);
    chk(4, 1);
    chk(5, 1);
    cyc(1);
    chk(0, 0);
    error_clear = 1'b1;
    cyc(2);
    chk(4, 1);
    partner_u.ser_steps(4, 1'b0);
    cyc(3);
    chk(3, 0);
    chk(4, 0);
    error_clear = 1'b0;
    hybrid_gap_threshold = 28'h000_0064;
    scale_direction_invert = 1'b1;
    partner_u.ser_steps(2, 1'b0);
    cyc(2);
    chk(3, 2);
    scale_direction_invert = 1'b0;
    scale_ratio_numerator = 8'h02;
    do_reset();
    partner_u.ser_steps(3, 1'b0);
    cyc(2);
    chk(3, -6);
    pulse(enc_step, 6);
    cyc(1);
    chk(3, 0);
    scale_ratio_numerator = 8'h01;
    scale_ratio_denominator = '0;
    do_reset();
    partner_u.ser_steps(3, 1'b0);
    cyc(2);
    chk(3, -3);
    scale_ratio_denominator = 21'h00_0001;
    hybrid_gap_clear_revs = 7'h02;
    do_reset();
    pulse(enc_step, 5);
    pulse(enc_rev_tick, 1);
    cyc(2);
    chk(3, 5);
    pulse(enc_rev_tick, 1);
    cyc(2);
    chk(3, 0);
    hybrid_gap_clear_revs = '0;
    scale_type_select = 2'h0;
    do_reset();
    pulse(enc_step, 4);
    partner_u.quad_steps(4);
    cyc(4);
    chk(6, 8);
    cyc(2);
    tally_and_finish();
  end
endmodule
